//--- tb/link_source.sv
`timescale 1ns/1ps
`default_nettype none
module link_source
    import spdif_status_pkg::*;
(
    // Link outputs
    output logic        link_clk_o,
    output link_frame_t frame_o
);
    // Link clock stands still between blocks
    initial
    begin
        link_clk_o = 1'b0;
        frame_o    = '0;
    end

    // One whole block from bit 0; optional sync code at its tail
    task automatic send_block(input logic [7:0] seed, input logic sync);
        int         f;
        logic [7:0] a;
        logic [7:0] b;
        #37;  // Keeps link edges off the system clock edges
        for (f = 0; f < BLOCK_FRAMES; f++)
        begin
            a = 8'(f / 8) + seed;
            b = 8'(f / 8) ^ seed;
            frame_o.block_start = (f == 0);
            frame_o.cs_a        = a[7 - f % 8];
            frame_o.cs_b        = b[7 - f % 8];
            frame_o.user_a      = b[7 - f % 8];
            frame_o.user_b      = a[7 - f % 8];
            // Seed zero sends digital silence
            frame_o.word        = (seed == 8'h00) ? 16'h0000 : 16'h1111;
            // Tail of the block carries the sync code when asked
            if (sync && f >= 184)
            begin
                case (f - 184)
                    4:       frame_o.word = SYNC_WORD_A;
                    5:       frame_o.word = SYNC_WORD_B;
                    6:       frame_o.word = 16'h0A01;
                    7:       frame_o.word = 16'h1000;
                    default: frame_o.word = 16'h0000;
                endcase
            end
            // Fields held 100 ns on both sides of the rising edge
            #100 link_clk_o = 1'b1;
            #100 link_clk_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import spdif_status_pkg::*;
;
    localparam int HOLD = 16;  // Short hold keeps the run brief

    // Design signals
    logic        clock_i = 1'b0;
    logic        srst_i;
    logic [8:0]  address;
    logic        read;
    logic        write;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        link_clk;
    link_frame_t frame;
    logic        irq;
    logic        nonaudio;
    logic [1:0]  lock;
    logic        pll_update;
    // Bookkeeping
    int          errors = 0;
    int          comparisons = 0;
    int          pulses = 0;
    int          j;
    logic [1:0]  m;

    // 40 MHz system clock
    always #12.5 clock_i = ~clock_i;

    // Lock update pulses, one per frame expected
    always @(posedge clock_i)
        if (pll_update === 1'b1)
            pulses <= pulses + 1;

    spdif_status_buffer_access #(.HOLD_FRAMES(HOLD), .SILENCE_FRAMES(8)) uut
    (
        .clock_i(clock_i), .srst_i(srst_i), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .link_clk_i(link_clk),
        .link_frame_i(frame), .irq_o(irq), .nonaudio_o(nonaudio),
        .pll_lock_mode_o(lock), .pll_update_o(pll_update)
    );

    link_source src (.link_clk_o(link_clk), .frame_o(frame));

    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Compare a data value
    task automatic chk_data(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Compare a flag
    task automatic chk_bit(string what, logic exp, logic got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic access(input logic wr, input logic [6:0] idx,
                          input logic [7:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clock_i);
        address <= {idx, 2'h0};
        read    <= !wr;
        write   <= wr;
        wdata   <= {24'h0, wd};
        n = 0;
        do
        begin
            @(posedge clock_i);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        if (waitreq !== 1'b0)
        begin
            errors++;
            $display("unexpected waitrequest expected 0 seen %b", waitreq);
            end_of_test();
        end
        // Answer edge: take read data, then release the request
        rd = rdata;
        read  <= 1'b0;
        write <= 1'b0;
        // Let a write land before its effect is looked at
        @(negedge clock_i);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [31:0] x;
        access(1'b1, idx, d, x);
    endtask

    task automatic rd_chk(string what, logic [6:0] idx, logic [31:0] exp);
        logic [31:0] x;
        access(1'b0, idx, 8'h00, x);
        chk_data(what, exp, x);
    endtask

    // Send one block and let the copy to E land
    task automatic block(input logic [7:0] seed, input logic sync);
        src.send_block(seed, sync);
        repeat (20) @(posedge clock_i);
    endtask

    // Expected user word: A bits in odd places, B bits in even
    function automatic logic [15:0] mix(input logic [7:0] a,
                                        input logic [7:0] b);
        int k;
        for (k = 0; k < 8; k++)
        begin
            mix[2 * k + 1] = a[k];
            mix[2 * k]     = b[k];
        end
    endfunction

    // Main sequence
    initial
    begin
        srst_i  = 1'b1;
        address = 9'h000;
        read    = 1'b0;
        write   = 1'b0;
        wdata   = 32'h0;
        be      = 4'hF;
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        chk_data("lock default", 32'(LOCK_WIDEBAND), 32'(lock));
        rd_chk("control reset", IDX_BUF_CTRL, 32'(BUF_CTRL_RESET));
        rd_chk("unmapped read", 7'h7F, 32'h0);
        chk_bit("irq reset", 1'b0, irq);
        $display("test reset done");
        // Every locking mode reaches the output
        for (m = 2'h0; m < 2'h3; m++)
        begin
            wr(IDX_BUF_CTRL, {2'h0, m, 4'h0});
            chk_data("lock mode", 32'(m), 32'(lock));
        end
        wr(IDX_BUF_CTRL, BUF_CTRL_RESET);
        wr(IDX_IRQ_MASK, 8'h03);
        pulses = 0;
        block(8'h10, 1'b0);
        chk_data("lock updates", 32'(BLOCK_FRAMES), pulses);
        chk_bit("irq on change", 1'b1, irq);
        rd_chk("irq status", IDX_IRQ_STATUS, 32'h3);
        wr(IDX_IRQ_STATUS, 8'h03);
        chk_bit("irq cleared", 1'b0, irq);
        rd_chk("copy bits", IDX_WIN_FIRST, 32'h0000_1010);
        $display("test change interrupt done");
        // Status buffer in each access mode, user buffer through the window
        for (j = 0; j < BUF_WORDS; j++)
            rd_chk("two byte", IDX_WIN_FIRST + 7'(j),
                   {16'h0, 8'(j) + 8'h10, 8'(j) ^ 8'h10});
        wr(IDX_BUF_CTRL, 8'h12);
        for (j = 0; j < BUF_WORDS; j++)
            rd_chk("one byte", IDX_WIN_FIRST + 7'(j),
                   {24'h0, 8'(j) + 8'h10});
        wr(IDX_BUF_CTRL, 8'h16);
        for (j = 0; j < BUF_WORDS; j++)
            rd_chk("stream", IDX_STREAM, {24'h0, 8'(j) ^ 8'h10});
        wr(IDX_BUF_CTRL, 8'h13);
        for (j = 0; j < BUF_WORDS; j++)
            rd_chk("user", IDX_WIN_FIRST + 7'(j),
                   {16'h0, mix(8'(j) ^ 8'h10, 8'(j) + 8'h10)});
        $display("test buffer access done");
        // Identical block, then sync code, then timeout of the flag
        block(8'h10, 1'b0);
        chk_bit("irq no change", 1'b0, irq);
        block(8'h20, 1'b1);
        chk_bit("nonaudio sync", 1'b1, nonaudio);
        rd_chk("format", IDX_RX_STATUS, 32'(FMT_BURST));
        rd_chk("preamble pc", IDX_PREAMBLE_PC, 32'h0A);
        rd_chk("preamble pd", IDX_PREAMBLE_PD, 32'h10);
        rd_chk("preamble pd lo", IDX_PREAMBLE_LS, 32'h00);
        block(8'h20, 1'b0);
        chk_bit("nonaudio timeout", 1'b0, nonaudio);
        rd_chk("format pcm", IDX_RX_STATUS, 32'(FMT_PCM));
        block(8'h00, 1'b0);
        rd_chk("format silence", IDX_RX_STATUS, 32'(FMT_SILENCE));
        block(8'h40, 1'b0);
        chk_bit("nonaudio status bit", 1'b1, nonaudio);
        rd_chk("nonaudio reg", IDX_RX_CHSTAT, 32'h1);
        $display("test non-audio done");
        end_of_test();
    end
endmodule
`default_nettype wire

//--- verilog/nonaudio_sync_scan.sv
`timescale 1ns/1ps
`default_nettype none
module nonaudio_sync_scan
    import spdif_status_pkg::*;
#(
    parameter int HOLD_FRAMES    = SYNC_HOLD_FRAMES,
    parameter int SILENCE_FRAMES = SILENCE_RUN_FRAMES
)
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    // Frame words
    input  wire logic        frame_stb_i,
    input  wire logic [15:0] word_i,
    // Detection results
    output logic             sync_seen_o,
    output logic             silent_o,
    output logic [31:0]      preamble_o
);
    localparam int HW = $clog2(HOLD_FRAMES + 1);
    localparam int SW = $clog2(SILENCE_FRAMES + 1);

    // Scan states
    typedef enum logic [3:0] {
        S_HUNT   = 4'h1,
        S_SECOND = 4'h2,
        S_PC     = 4'h4,
        S_PD     = 4'h8
    } scan_state_t;

    scan_state_t   state_q;     // Position in the sync code
    logic [2:0]    zero_run_q;  // Zero words seen, saturating
    logic [HW-1:0] hold_q;      // Frames since last sync code
    logic [SW-1:0] quiet_q;     // Run of all-zero frames

    wire is_zero  = (word_i == 16'h0000);
    wire zeros_ok = (zero_run_q >= SYNC_ZERO_WORDS);
    wire sync_hit = frame_stb_i && (state_q == S_SECOND)
                    && (word_i == SYNC_WORD_B);
    wire hold_end = (hold_q == HW'(HOLD_FRAMES));
    assign silent_o = (quiet_q == SW'(SILENCE_FRAMES));

    // Walk through zeros, first and second sync word, then burst info
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            state_q <= S_HUNT;
        else if (frame_stb_i)
        begin
            unique case (state_q)
                S_HUNT:   if (zeros_ok && word_i == SYNC_WORD_A)
                              state_q <= S_SECOND;
                S_SECOND: state_q <= sync_hit ? S_PC : S_HUNT;
                S_PC:     state_q <= S_PD;
                S_PD:     state_q <= S_HUNT;
                default:  state_q <= S_HUNT;
            endcase
        end
    end

    // Zero-word run; only four are needed, so it saturates
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            zero_run_q <= 3'h0;
        else if (frame_stb_i)
            zero_run_q <= !is_zero ? 3'h0
                        : zeros_ok ? zero_run_q : zero_run_q + 3'h1;
    end

    // Burst preamble words follow the sync code
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            preamble_o <= 32'h0000_0000;
        else if (frame_stb_i && state_q == S_PC)
            preamble_o[31:16] <= word_i;
        else if (frame_stb_i && state_q == S_PD)
            preamble_o[15:0] <= word_i;
    end

    // Sync flag holds for a fixed number of frames after each code
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            sync_seen_o <= 1'b0;
            hold_q      <= '0;
        end
        else if (sync_hit)
        begin
            sync_seen_o <= 1'b1;
            hold_q      <= '0;
        end
        else if (frame_stb_i && sync_seen_o)
        begin
            if (hold_end)
                sync_seen_o <= 1'b0;
            else
                hold_q <= hold_q + HW'(1);
        end
    end

    // Digital silence: a long run of zero words
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            quiet_q <= '0;
        else if (frame_stb_i)
            quiet_q <= !is_zero ? '0
                     : silent_o ? quiet_q : quiet_q + SW'(1);
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_code_tail;
        frame_stb_i && state_q == S_SECOND && word_i == SYNC_WORD_B;
    endsequence

    a_sync_detect: assert property (
        s_code_tail |=> sync_seen_o && state_q == S_PC)
        else $error("sync code did not raise the flag");

    a_sync_hold: assert property (
        $fell(sync_seen_o) |-> $past(hold_q) == HW'(HOLD_FRAMES))
        else $error("sync flag dropped before the hold ended");

endmodule
`default_nettype wire

//--- verilog/spdif_status_buffer_access.sv
`timescale 1ns/1ps
`default_nettype none
module spdif_status_buffer_access
    import spdif_status_pkg::*;
#(
    parameter int HOLD_FRAMES    = SYNC_HOLD_FRAMES,
    parameter int SILENCE_FRAMES = SILENCE_RUN_FRAMES
)
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    // Avalon-MM register slave
    input  wire logic [8:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Incoming link, asynchronous to clock_i
    input  wire logic        link_clk_i,
    input  wire link_frame_t link_frame_i,
    // Status and control outputs
    output logic             irq_o,
    output logic             nonaudio_o,
    output logic [1:0]       pll_lock_mode_o,
    output logic             pll_update_o
);

    // Link synchronisers
    logic        lclk_meta_q;   // First stage, read only by next
    logic        lclk_sync_q;   // Safe link clock level
    logic        lclk_prev_q;   // For edge detection
    link_frame_t frame_meta_q;  // First stage of frame bits
    link_frame_t frame_sync_q;  // Frame bits, safe to use

    // Block buffers
    logic [BUF_WORDS-1:0][15:0] cs_d_q;    // Status, being filled
    logic [BUF_WORDS-1:0][15:0] cs_e_q;    // Status, host view
    logic [BUF_WORDS-1:0][15:0] user_d_q;  // User, being filled
    logic [BUF_WORDS-1:0][15:0] user_e_q;  // User, host view
    logic [7:0]  frame_idx_q;  // Frame within block, 192 = idle
    logic        xfer_pend_q;  // Complete D block waits for copy

    // Registers
    logic [7:0]  ctrl_q;       // Buffer control
    logic [1:0]  mask_q;       // Interrupt enables
    logic [1:0]  irq_stat_q;   // Sticky change flags
    logic [4:0]  stream_q;     // Auto-increment entry pointer
    logic        ack_q;        // Bus answer cycle
    logic [31:0] rdata_q;      // Read data register

    // Detector results
    logic        sync_seen;
    logic        silent;
    logic [31:0] preamble;

    // Sample the link clock and its frame twice before use
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            lclk_meta_q  <= 1'b0;
            lclk_sync_q  <= 1'b0;
            lclk_prev_q  <= 1'b0;
            frame_meta_q <= '0;
            frame_sync_q <= '0;
        end
        else
        begin
            lclk_meta_q  <= link_clk_i;
            lclk_sync_q  <= lclk_meta_q;
            lclk_prev_q  <= lclk_sync_q;
            frame_meta_q <= link_frame_i;
            frame_sync_q <= frame_meta_q;
        end
    end

    // Rising link edge marks one frame; data held steady around it
    wire frame_stb = lclk_sync_q && !lclk_prev_q;

    // Control fields
    wire       buf_user  = ctrl_q[BIT_BUF_SELECT];
    wire       one_byte  = ctrl_q[BIT_WIDTH_SEL] && !buf_user;
    wire       pick_b    = ctrl_q[BIT_CHAN_PICK];
    assign pll_lock_mode_o = ctrl_q[LOCK_MODE_LSB +: 2];

    // Fill position: word, and bit counted from the MSB
    wire       at_start  = frame_stb && frame_sync_q.block_start;
    wire [7:0] wr_idx    = at_start ? 8'h00 : frame_idx_q;
    wire       wr_en     = frame_stb
                           && (at_start || frame_idx_q < 8'(BLOCK_FRAMES));
    wire [4:0] wr_word   = wr_idx[7:3];
    wire [2:0] wr_pos    = ~wr_idx[2:0];
    wire       last_bit  = wr_en && wr_idx == 8'(BLOCK_FRAMES - 1);

    // Copy waits out a pending read unless the next frame forces it
    wire commit = xfer_pend_q && (!avs_read_i || frame_stb);

    // Differences between the finished block and the host view
    wire cs_diff   = (cs_d_q != cs_e_q);
    wire user_diff = (user_d_q != user_e_q);

    // Frame position; frames after a full block wait for a start
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            frame_idx_q <= 8'(BLOCK_FRAMES);
        else if (wr_en)
            frame_idx_q <= wr_idx + 8'h01;
    end

    // Fill the D buffers bit by bit as frames arrive
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cs_d_q   <= '0;
            user_d_q <= '0;
        end
        else if (wr_en)
        begin
            // Status A in the upper byte, B in the lower
            cs_d_q[wr_word][{1'b1, wr_pos}] <= frame_sync_q.cs_a;
            cs_d_q[wr_word][{1'b0, wr_pos}] <= frame_sync_q.cs_b;
            // User bits interleaved A then B
            user_d_q[wr_word][{wr_pos, 1'b1}] <= frame_sync_q.user_a;
            user_d_q[wr_word][{wr_pos, 1'b0}] <= frame_sync_q.user_b;
        end
    end

    // A full block is flagged; copy clears it, a new one wins
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            xfer_pend_q <= 1'b0;
        else
            xfer_pend_q <= last_bit || (xfer_pend_q && !commit);
    end

    // Whole-block copy; reads old D even on a frame cycle
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cs_e_q   <= '0;
            user_e_q <= '0;
        end
        else if (commit)
        begin
            cs_e_q   <= cs_d_q;
            user_e_q <= user_d_q;
        end
    end

    // Lock updates follow the preamble-timed frame edge only
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            pll_update_o <= 1'b0;
        else
            pll_update_o <= frame_stb;
    end

    // Non-audio detection and burst info
    nonaudio_sync_scan #(
        .HOLD_FRAMES    (HOLD_FRAMES),
        .SILENCE_FRAMES (SILENCE_FRAMES)
    ) u_scan (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .frame_stb_i (frame_stb),
        .word_i      (frame_sync_q.word),
        .sync_seen_o (sync_seen),
        .silent_o    (silent),
        .preamble_o  (preamble)
    );

    // Received status bit 1 of the picked channel, second MSB of byte 0
    wire cs_bit1 = pick_b ? cs_e_q[0][6] : cs_e_q[0][14];
    // Indicator only; audio keeps flowing unmuted
    assign nonaudio_o = sync_seen || cs_bit1;

    // Detected input format
    wire [7:0] fmt_code = sync_seen ? FMT_BURST
                        : silent    ? FMT_SILENCE : FMT_PCM;

    // Bus decode
    wire       bus_req   = avs_read_i || avs_write_i;
    wire       accept    = bus_req && ack_q;
    wire [6:0] idx       = avs_address_i[8:2];
    wire       in_win    = idx >= IDX_WIN_FIRST && idx <= IDX_WIN_LAST;
    wire [4:0] win_entry = 5'(idx - IDX_WIN_FIRST);
    wire       wr_ok     = accept && avs_write_i && avs_byteenable_i[0];
    wire       wr_ctrl   = wr_ok && idx == IDX_BUF_CTRL;
    wire       wr_mask   = wr_ok && idx == IDX_IRQ_MASK;
    wire       wr_clear  = wr_ok && idx == IDX_IRQ_STATUS;
    wire       rd_stream = accept && avs_read_i && idx == IDX_STREAM;
    wire       stream_end = stream_q == 5'(BUF_WORDS - 1);

    // Picked words as named wires, so the read mux sees every change
    wire [15:0] win_word = buf_user ? user_e_q[win_entry]
                                    : cs_e_q[win_entry];
    wire [15:0] str_word = buf_user ? user_e_q[stream_q] : cs_e_q[stream_q];

    // One entry as the host sees it; every input is an argument
    function automatic logic [31:0] entry_data(input logic [15:0] w,
                                               input logic        one,
                                               input logic        pick);
        if (one)
            entry_data = {24'h0, pick ? w[7:0] : w[15:8]};
        else
            entry_data = {16'h0, w};
    endfunction

    // Read data for each mapped index
    wire [31:0] rd_mux =
          in_win                     ? entry_data(win_word, one_byte, pick_b)
        : idx == IDX_STREAM          ? entry_data(str_word, one_byte, pick_b)
        : idx == IDX_RX_STATUS       ? {24'h0, fmt_code}
        : idx >= IDX_PREAMBLE_PC && idx <= IDX_PREAMBLE_LS
                                     ? {24'h0, preamble[
                                        8*(3 - 32'(idx - IDX_PREAMBLE_PC))
                                        +: 8]}
        : idx == IDX_IRQ_STATUS      ? {30'h0, irq_stat_q}
        : idx == IDX_IRQ_MASK        ? {30'h0, mask_q}
        : idx == IDX_BUF_CTRL        ? {24'h0, ctrl_q}
        : idx == IDX_RX_CHSTAT       ? {31'h0, nonaudio_o}
        : 32'h0000_0000;  // Unmapped reads as zero

    // One wait state: answer on the second cycle of every request
    assign avs_waitrequest_o = bus_req && !ack_q;
    assign avs_readdata_o    = rdata_q;

    // Answer timing and read data capture
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= bus_req && !ack_q;
            if (avs_read_i && !ack_q)
                rdata_q <= rd_mux;
        end
    end

    // Control and mask registers
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            ctrl_q <= BUF_CTRL_RESET;
            mask_q <= 2'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= avs_writedata_i[7:0];
            if (wr_mask)
                mask_q <= avs_writedata_i[1:0];
        end
    end

    // Stream pointer: each read steps on, wraps, control write rewinds
    always_ff @(posedge clock_i)
    begin
        if (srst_i || wr_ctrl)
            stream_q <= 5'h00;
        else if (rd_stream)
            stream_q <= stream_end ? 5'h00 : stream_q + 5'h01;
    end

    // Change flags: set on a changing copy, write one to clear
    wire [1:0] irq_set = {commit && user_diff, commit && cs_diff};
    wire [1:0] irq_clr = wr_clear ? avs_writedata_i[1:0] : 2'h0;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            irq_stat_q <= 2'h0;
        else
            irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
    end

    // Interrupt gated by the mask
    assign irq_o = |(irq_stat_q & mask_q);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_change_copy;
        commit && cs_diff;
    endsequence

    a_cs_change_irq: assert property (
        s_change_copy ##0 mask_q[IRQ_CS_CHANGE] |=> irq_o)
        else $error("status change did not interrupt");

    a_no_change_quiet: assert property (
        $rose(irq_stat_q[IRQ_CS_CHANGE]) |-> $past(commit) && $past(cs_diff))
        else $error("status flag set without a change");

    a_user_change: assert property (
        commit && user_diff |=> irq_stat_q[IRQ_USER_CHANGE])
        else $error("user change not flagged");

    a_copy_whole: assert property (
        commit |=> cs_e_q == $past(cs_d_q) && user_e_q == $past(user_d_q))
        else $error("block copy incomplete");

    a_copy_atomic: assert property (
        avs_read_i && !frame_stb |=> $stable(cs_e_q) && $stable(user_e_q))
        else $error("host view changed during a read");

    sequence s_win_read;
        avs_read_i && !ack_q && in_win && !one_byte;
    endsequence

    a_two_byte_order: assert property (
        s_win_read ##1 !$changed(cs_e_q) && !buf_user |->
        avs_readdata_o[15:0] == cs_e_q[win_entry])
        else $error("two-byte read order wrong");

    a_stream_step: assert property (
        rd_stream && !stream_end |=> stream_q == $past(stream_q) + 5'h01)
        else $error("stream pointer did not step");

    a_bus_answer: assert property (
        bus_req && !ack_q |=> !avs_waitrequest_o ##1 !ack_q)
        else $error("bus answer not after one wait");

    a_nonaudio_flag: assert property (
        $rose(sync_seen) |=> nonaudio_o)
        else $error("non-audio bit missing");

endmodule
`default_nettype wire

//--- verilog/spdif_status_pkg.sv
package spdif_status_pkg;

    // Buffer geometry
    localparam int BUF_WORDS    = 24;   // 16-bit words per E buffer
    localparam int BLOCK_FRAMES = 192;  // Frames in one status block

    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_RX_STATUS   = 7'h08;
    localparam logic [6:0] IDX_PREAMBLE_PC = 7'h09;
    localparam logic [6:0] IDX_PREAMBLE_PD = 7'h0B;
    localparam logic [6:0] IDX_PREAMBLE_LS = 7'h0C;
    localparam logic [6:0] IDX_IRQ_STATUS  = 7'h20;
    localparam logic [6:0] IDX_IRQ_MASK    = 7'h21;
    localparam logic [6:0] IDX_BUF_CTRL    = 7'h24;
    localparam logic [6:0] IDX_RX_CHSTAT   = 7'h25;
    localparam logic [6:0] IDX_STREAM      = 7'h30;
    localparam logic [6:0] IDX_WIN_FIRST   = 7'h3A;
    localparam logic [6:0] IDX_WIN_LAST    = 7'h51;

    // Buffer control fields
    localparam int BIT_BUF_SELECT  = 0;
    localparam int BIT_WIDTH_SEL   = 1;
    localparam int BIT_CHAN_PICK   = 2;
    localparam int LOCK_MODE_LSB   = 4;
    localparam logic [7:0] BUF_CTRL_RESET = 8'h10;

    // Clock-recovery locking modes
    localparam logic [1:0] LOCK_LEGACY   = 2'h0;
    localparam logic [1:0] LOCK_WIDEBAND = 2'h1;
    localparam logic [1:0] LOCK_INBAND   = 2'h2;

    // Interrupt status bits
    localparam int IRQ_CS_CHANGE   = 0;
    localparam int IRQ_USER_CHANGE = 1;

    // Format codes of the receiver status register
    localparam logic [7:0] FMT_PCM     = 8'h01;
    localparam logic [7:0] FMT_BURST   = 8'h02;
    localparam logic [7:0] FMT_LD_COMP = 8'h04;
    localparam logic [7:0] FMT_CD_COMP = 8'h08;
    localparam logic [7:0] FMT_HD_PCM  = 8'h10;
    localparam logic [7:0] FMT_SILENCE = 8'h20;

    // Non-audio sync code
    localparam logic [2:0]  SYNC_ZERO_WORDS    = 3'h4;
    localparam logic [15:0] SYNC_WORD_A        = 16'hF872;
    localparam logic [15:0] SYNC_WORD_B        = 16'h4E1F;
    localparam int          SYNC_HOLD_FRAMES   = 4096;
    localparam int          SILENCE_RUN_FRAMES = 2048;

    // One frame as presented on the link
    typedef struct packed {
        logic        block_start;  // First frame of a block
        logic        cs_a;         // Channel-status bit, subframe A
        logic        cs_b;         // Channel-status bit, subframe B
        logic        user_a;       // User bit, subframe A
        logic        user_b;       // User bit, subframe B
        logic [15:0] word;         // Audio word, subframe A
    } link_frame_t;

endpackage
